// *** core/mfr_responder.v ***
`default_nettype none
`include "mfr_defines.vh"

module mfr_responder (
	input wire i_clk_sys,
	input wire i_rst,
	// Received frame bytes, CRC already stripped by the framer
	input wire i_rx_valid,
	input wire [7:0] i_rx_data,
	input wire i_rx_end,
	input wire i_rx_crc_ok,
	// Reply bytes to the framer, which appends the CRC
	input wire i_tx_ready,
	output reg o_tx_valid,
	output reg [7:0] o_tx_data,
	output reg o_tx_last,
	output wire o_busy,
	// Register map access
	output wire [15:0] o_reg_addr,
	output wire [15:0] o_reg_wdata,
	output wire o_reg_wr,
	input wire i_reg_wr_ok,
	input wire i_reg_val_ok,
	input wire i_reg_rd_ok,
	input wire [15:0] i_reg_rdata,
	// Communication counter events
	output wire o_evt_bad_format,
	output wire o_evt_illegal_func,
	output wire o_evt_invalid_addr,
	output wire o_evt_illegal_reg,
	output wire o_evt_illegal_write
);
	// Main states
	localparam S_IDLE = 3'h0;
	localparam S_CHECK = 3'h1;
	localparam S_VALID = 3'h2;
	localparam S_WRITE = 3'h3;
	localparam S_READ = 3'h4;
	localparam S_ERR = 3'h5;
	localparam S_TX = 3'h6;

	reg [2:0] state_r; // Current state
	reg [7:0] rx_len_r; // Bytes stored so far
	reg rx_ovf_r; // Frame outgrew the buffer
	reg [7:0] len_r; // Length of the accepted frame
	reg [7:0] fc_r; // Function byte
	reg [7:0] b2_r; // Header bytes 2..6
	reg [7:0] b3_r;
	reg [7:0] b4_r;
	reg [7:0] b5_r;
	reg [7:0] b6_r;
	reg [7:0] ptr_r; // Buffer index of current register field
	reg [6:0] idx_r; // Register walk index or countdown
	reg [15:0] waddr_r; // Register address during a write walk
	reg phase_r; // Read walk: 0 high byte, 1 low byte
	reg [7:0] lo_hold_r; // Low data byte waiting for its slot
	reg [2:0] kind_r; // Pending error kind
	reg exc_r; // Reply is an exception
	reg [7:0] code_r; // Exception code for the reply
	reg [4:0] evt_r; // Registered counter pulses
	reg [7:0] tx_idx_r; // Next reply byte
	reg [7:0] tx_len_r; // Reply length

	wire [7:0] buf_a;
	wire [7:0] buf_b;
	wire [7:0] map_code;
	wire [4:0] map_evt;
	wire [15:0] qty = {b4_r, b5_r}; // Write register count
	wire rx_take = (state_r == S_IDLE) && i_rx_valid && !rx_ovf_r;

	// Buffer port mux: receive, then in-place read data
	reg buf_we;
	reg [7:0] buf_waddr;
	reg [7:0] buf_wdata;
	reg [7:0] rd_a;
	always @*
	begin
		buf_we = 1'b0;
		buf_waddr = rx_len_r;
		buf_wdata = i_rx_data;
		rd_a = ptr_r;
		if (rx_take)
		begin
			buf_we = 1'b1;
		end
		else if (state_r == S_READ && !phase_r && i_reg_rd_ok)
		begin
			buf_we = 1'b1;
			buf_waddr = ptr_r;
			buf_wdata = i_reg_rdata[15:8];
		end
		else if (state_r == S_READ && phase_r)
		begin
			buf_we = 1'b1;
			buf_waddr = ptr_r + 8'h01;
			buf_wdata = lo_hold_r;
		end
		if (state_r == S_TX)
		begin
			rd_a = exc_r ? 8'h00 : tx_idx_r;
		end
	end

	mfr_byte_buf #(
		.AW(8)
	) u_buf (
		.i_clk_sys(i_clk_sys),
		.i_we(buf_we),
		.i_waddr(buf_waddr),
		.i_wdata(buf_wdata),
		.i_raddr_a(rd_a),
		.i_raddr_b(ptr_r + 8'h01),
		.o_rdata_a(buf_a),
		.o_rdata_b(buf_b)
	);

	mfr_exc_map u_map (
		.i_kind(kind_r),
		.o_code(map_code),
		.o_evt(map_evt)
	);

	// Register map side; write data comes straight from the frame
	assign o_reg_addr = (state_r == S_READ) ? {buf_a, buf_b} : waddr_r;
	assign o_reg_wdata = {buf_a, buf_b};
	// Writes only after every register passed validation
	assign o_reg_wr = (state_r == S_WRITE);
	assign o_busy = (state_r != S_IDLE);
	assign o_evt_bad_format = evt_r[`MFR_EV_FMT];
	assign o_evt_illegal_func = evt_r[`MFR_EV_FUNC];
	assign o_evt_invalid_addr = evt_r[`MFR_EV_ADDR];
	assign o_evt_illegal_reg = evt_r[`MFR_EV_REG];
	assign o_evt_illegal_write = evt_r[`MFR_EV_WR];

	// Reply byte for the current index
	reg [7:0] tx_byte;
	always @*
	begin
		tx_byte = buf_a;
		if (exc_r)
		begin
			case (tx_idx_r)
				8'h00: tx_byte = buf_a;
				8'h01: tx_byte = fc_r | `MFR_EXC_FLAG;
				default: tx_byte = code_r;
			endcase
		end
	end

	// Receive, check, walk and reply sequencer
	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= S_IDLE;
			rx_len_r <= 8'h00;
			rx_ovf_r <= 1'b0;
			len_r <= 8'h00;
			fc_r <= 8'h00;
			b2_r <= 8'h00;
			b3_r <= 8'h00;
			b4_r <= 8'h00;
			b5_r <= 8'h00;
			b6_r <= 8'h00;
			ptr_r <= 8'h00;
			idx_r <= 7'h00;
			waddr_r <= 16'h0000;
			phase_r <= 1'b0;
			lo_hold_r <= 8'h00;
			kind_r <= 3'h0;
			exc_r <= 1'b0;
			code_r <= 8'h00;
			evt_r <= 5'h00;
			tx_idx_r <= 8'h00;
			tx_len_r <= 8'h00;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
			o_tx_last <= 1'b0;
		end
		else
		begin
			evt_r <= 5'h00;
			case (state_r)
				S_IDLE:
				begin
					// Header bytes are kept aside for the checks
					if (rx_take)
					begin
						case (rx_len_r)
							8'h01: fc_r <= i_rx_data;
							8'h02: b2_r <= i_rx_data;
							8'h03: b3_r <= i_rx_data;
							8'h04: b4_r <= i_rx_data;
							8'h05: b5_r <= i_rx_data;
							8'h06: b6_r <= i_rx_data;
							default: fc_r <= fc_r;
						endcase
						rx_len_r <= rx_len_r + 8'h01;
						if (rx_len_r == `MFR_BUF_LAST)
						begin
							rx_ovf_r <= 1'b1;
						end
					end
					if (i_rx_end)
					begin
						rx_len_r <= 8'h00;
						rx_ovf_r <= 1'b0;
						len_r <= rx_len_r;
						if (i_rx_crc_ok && !rx_ovf_r && rx_len_r != 8'h00)
						begin
							state_r <= S_CHECK;
						end
					end
				end
				S_CHECK:
				begin
					exc_r <= 1'b0;
					state_r <= S_IDLE;
					case (fc_r)
						`MFR_FC_LOOP:
						begin
							if (len_r != `MFR_LOOP_LEN)
							begin
								kind_r <= `MFR_ERR_FMT;
								state_r <= S_ERR;
							end
							else if ({b2_r, b3_r} != 16'h0000)
							begin
								kind_r <= `MFR_ERR_FUNC;
								state_r <= S_ERR;
							end
							else
							begin
								tx_len_r <= len_r;
								tx_idx_r <= 8'h00;
								state_r <= S_TX;
							end
						end
						`MFR_FC_WRITE:
						begin
							if (len_r < `MFR_WR_HDR)
							begin
								kind_r <= `MFR_ERR_WFMT;
								state_r <= S_ERR;
							end
							else if (qty == 16'h0000 || qty > `MFR_MAX_REGS)
							begin
								kind_r <= `MFR_ERR_WQTY;
								state_r <= S_ERR;
							end
							else if ({8'h00, b6_r} != {qty[14:0], 1'b0} ||
								{1'b0, len_r} != {1'b0, `MFR_WR_HDR} + {1'b0, b6_r})
							begin
								kind_r <= `MFR_ERR_WFMT;
								state_r <= S_ERR;
							end
							else
							begin
								ptr_r <= `MFR_WR_HDR;
								idx_r <= 7'h00;
								waddr_r <= {b2_r, b3_r};
								state_r <= S_VALID;
							end
						end
						`MFR_FC_SCAT:
						begin
							if (len_r < `MFR_SC_HDR || b2_r != len_r - 8'h03 || b2_r[0] ||
								b2_r < 8'h04 || b2_r > `MFR_SC_MAXQ)
							begin
								kind_r <= `MFR_ERR_FMT;
								state_r <= S_ERR;
							end
							else if (b3_r != `MFR_SUB_SCAT)
							begin
								kind_r <= `MFR_ERR_FUNC;
								state_r <= S_ERR;
							end
							else
							begin
								ptr_r <= `MFR_SC_HDR;
								// Query length is two plus two per address
								idx_r <= b2_r[7:1] - 7'h02;
								phase_r <= 1'b0;
								state_r <= S_READ;
							end
						end
						// Other function codes belong to other handlers
						default: state_r <= S_IDLE;
					endcase
				end
				S_VALID:
				begin
					if (!i_reg_wr_ok)
					begin
						kind_r <= `MFR_ERR_WADDR;
						state_r <= S_ERR;
					end
					else if (!i_reg_val_ok)
					begin
						kind_r <= `MFR_ERR_WVAL;
						state_r <= S_ERR;
					end
					else if (idx_r == qty[6:0] - 7'h01)
					begin
						// All passed: rewind for the real writes
						ptr_r <= `MFR_WR_HDR;
						idx_r <= 7'h00;
						waddr_r <= {b2_r, b3_r};
						state_r <= S_WRITE;
					end
					else
					begin
						ptr_r <= ptr_r + 8'h02;
						idx_r <= idx_r + 7'h01;
						waddr_r <= waddr_r + 16'h0001;
					end
				end
				S_WRITE:
				begin
					ptr_r <= ptr_r + 8'h02;
					idx_r <= idx_r + 7'h01;
					waddr_r <= waddr_r + 16'h0001;
					if (idx_r == qty[6:0] - 7'h01)
					begin
						tx_len_r <= `MFR_WR_ACK_LEN;
						tx_idx_r <= 8'h00;
						state_r <= S_TX;
					end
				end
				S_READ:
				begin
					if (!phase_r)
					begin
						if (!i_reg_rd_ok)
						begin
							kind_r <= `MFR_ERR_RADDR;
							state_r <= S_ERR;
						end
						else
						begin
							lo_hold_r <= i_reg_rdata[7:0];
							phase_r <= 1'b1;
						end
					end
					else
					begin
						phase_r <= 1'b0;
						ptr_r <= ptr_r + 8'h02;
						idx_r <= idx_r - 7'h01;
						if (idx_r == 7'h00)
						begin
							tx_len_r <= len_r;
							tx_idx_r <= 8'h00;
							state_r <= S_TX;
						end
					end
				end
				S_ERR:
				begin
					// One event pulse per failed request
					evt_r <= map_evt;
					code_r <= map_code;
					exc_r <= 1'b1;
					tx_len_r <= `MFR_EXC_LEN;
					tx_idx_r <= 8'h00;
					state_r <= S_TX;
				end
				S_TX:
				begin
					// Registered byte stream; framer adds CRC after last
					if (o_tx_valid && i_tx_ready && o_tx_last)
					begin
						o_tx_valid <= 1'b0;
						o_tx_last <= 1'b0;
						state_r <= S_IDLE;
					end
					else if (!o_tx_valid || i_tx_ready)
					begin
						o_tx_valid <= 1'b1;
						o_tx_data <= tx_byte;
						o_tx_last <= (tx_idx_r == tx_len_r - 8'h01);
						tx_idx_r <= tx_idx_r + 8'h01;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // mfr_responder

`default_nettype wire

// *** core/mfr_defines.vh ***
`ifndef MFR_DEFINES_VH
`define MFR_DEFINES_VH

// Function codes handled here
`define MFR_FC_LOOP 8'h08
`define MFR_FC_WRITE 8'h10
`define MFR_FC_SCAT 8'h64
// Only accepted scattered-read subfunction
`define MFR_SUB_SCAT 8'h04
// Exception codes and the exception flag on the function byte
`define MFR_EXC_ADDR 8'h02
`define MFR_EXC_VALUE 8'h03
`define MFR_EXC_FLAG 8'h80
// Register count limit per request
`define MFR_MAX_REGS 16'h0064
// Frame lengths without CRC
`define MFR_LOOP_LEN 8'h06
`define MFR_WR_HDR 8'h07
`define MFR_SC_HDR 8'h05
`define MFR_SC_MAXQ 8'hca
`define MFR_WR_ACK_LEN 8'h06
`define MFR_EXC_LEN 8'h03
// Largest frame kept; longer frames are dropped
`define MFR_BUF_LAST 8'hff
// Error kinds
`define MFR_ERR_FMT 3'h1
`define MFR_ERR_FUNC 3'h2
`define MFR_ERR_WADDR 3'h3
`define MFR_ERR_WQTY 3'h4
`define MFR_ERR_WFMT 3'h5
`define MFR_ERR_WVAL 3'h6
`define MFR_ERR_RADDR 3'h7
// Event vector bit positions
`define MFR_EV_FMT 0
`define MFR_EV_FUNC 1
`define MFR_EV_ADDR 2
`define MFR_EV_REG 3
`define MFR_EV_WR 4

`endif

// *** core/mfr_byte_buf.v ***
`default_nettype none

// Frame store in flip-flops: one write port, two read ports
module mfr_byte_buf #(
	parameter AW = 8
) (
	input wire i_clk_sys,
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [7:0] i_wdata,
	input wire [AW-1:0] i_raddr_a,
	input wire [AW-1:0] i_raddr_b,
	output wire [7:0] o_rdata_a,
	output wire [7:0] o_rdata_b
);
	// Byte array; contents need no reset, lengths guard them
	reg [7:0] mem [0:(1<<AW)-1];

	// Single byte write per cycle
	always @(posedge i_clk_sys)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Combinational reads
	assign o_rdata_a = mem[i_raddr_a];
	assign o_rdata_b = mem[i_raddr_b];
endmodule // mfr_byte_buf

`default_nettype wire

// *** core/mfr_exc_map.v ***
`default_nettype none
`include "mfr_defines.vh"

// Maps an error kind to its exception code and counter events
module mfr_exc_map (
	input wire [2:0] i_kind,
	output reg [7:0] o_code,
	output reg [4:0] o_evt
);
	// Pure decode, no state
	always @*
	begin
		o_code = `MFR_EXC_VALUE;
		o_evt = 5'h00;
		case (i_kind)
			`MFR_ERR_FMT: o_evt[`MFR_EV_FMT] = 1'b1;
			`MFR_ERR_FUNC: o_evt[`MFR_EV_FUNC] = 1'b1;
			`MFR_ERR_WADDR:
			begin
				o_code = `MFR_EXC_ADDR;
				o_evt[`MFR_EV_ADDR] = 1'b1;
				o_evt[`MFR_EV_WR] = 1'b1;
			end
			`MFR_ERR_WQTY:
			begin
				o_evt[`MFR_EV_REG] = 1'b1;
				o_evt[`MFR_EV_WR] = 1'b1;
			end
			`MFR_ERR_WFMT:
			begin
				o_evt[`MFR_EV_FMT] = 1'b1;
				o_evt[`MFR_EV_WR] = 1'b1;
			end
			`MFR_ERR_WVAL: o_evt[`MFR_EV_WR] = 1'b1;
			`MFR_ERR_RADDR:
			begin
				o_code = `MFR_EXC_ADDR;
				o_evt[`MFR_EV_ADDR] = 1'b1;
			end
			default: o_evt = 5'h00;
		endcase
	end
endmodule // mfr_exc_map

`default_nettype wire

// *** tb/mfr_checker.sv ***
`default_nettype none

// Port-level watcher for the function responder
module mfr_checker (
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_rx_end,
	input wire i_rx_crc_ok,
	input wire i_tx_ready,
	input wire o_tx_valid,
	input wire [7:0] o_tx_data,
	input wire o_tx_last,
	input wire o_busy,
	input wire o_reg_wr,
	input wire i_reg_wr_ok,
	input wire i_reg_val_ok,
	input wire o_evt_bad_format,
	input wire o_evt_illegal_func,
	input wire o_evt_invalid_addr,
	input wire o_evt_illegal_reg,
	input wire o_evt_illegal_write
);
	// Any counter event this cycle
	wire any_evt = o_evt_bad_format | o_evt_illegal_func | o_evt_invalid_addr | o_evt_illegal_reg | o_evt_illegal_write;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_crc_drop: assert property (i_rx_end && !i_rx_crc_ok && !o_busy |=> !o_busy)
		else $error("busy after bad CRC");
	a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
		else $error("reply byte not held");
	a_reply_end: assert property (o_tx_valid && i_tx_ready && o_tx_last |=> !o_tx_valid && !o_busy)
		else $error("reply did not end");
	a_tx_busy: assert property (o_tx_valid |-> o_busy)
		else $error("reply byte while idle");
	a_evt_reply: assert property (any_evt |=> o_tx_valid && !o_tx_last)
		else $error("event without exception reply");
	a_reg_pair: assert property (o_evt_illegal_reg |-> o_evt_illegal_write)
		else $error("register event alone");
	a_wr_busy: assert property (o_reg_wr |-> o_busy)
		else $error("write while idle");
	a_wr_legal: assert property (o_reg_wr |-> i_reg_wr_ok && i_reg_val_ok)
		else $error("illegal register written");
	a_evt_pulse: assert property (o_evt_illegal_write |=> !o_evt_illegal_write)
		else $error("write event too long");

	c_write: cover property (o_reg_wr);
	c_stall: cover property (o_tx_valid && !i_tx_ready);
	c_evt: cover property (o_evt_illegal_write);
endmodule // mfr_checker

bind mfr_responder mfr_checker u_chk (.i_clk_sys, .i_rst, .i_rx_end, .i_rx_crc_ok, .i_tx_ready,
	.o_tx_valid, .o_tx_data, .o_tx_last, .o_busy, .o_reg_wr, .i_reg_wr_ok, .i_reg_val_ok, .o_evt_bad_format,
	.o_evt_illegal_func, .o_evt_invalid_addr, .o_evt_illegal_reg, .o_evt_illegal_write);

`default_nettype wire

// *** tb/mfr_master.sv ***
`default_nettype none

// Polling master with framer: sends frames, takes replies
module mfr_master (
	input wire logic i_clk_sys,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_end,
	output logic o_rx_crc_ok,
	output logic o_tx_ready,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rb [0:15]; // Reply bytes taken
	logic [7:0] rn; // Reply byte count
	bit slow; // Stall every other cycle

	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_rx_end = 1'b0;
		o_rx_crc_ok = 1'b0;
		o_tx_ready = 1'b0;
	end

	// One frame out, reply in; lim bounds the wait
	task automatic xfer(input logic [7:0] n, input logic [87:0] f, input bit ok, input int lim);
		int i;
		rn = 8'h00;
		for (i = 0; i < n; i++)
		begin
			@(posedge i_clk_sys);
			#1;
			o_rx_valid = 1'b1;
			o_rx_data = f[8*(n-1-i)+:8];
		end
		@(posedge i_clk_sys);
		#1;
		o_rx_valid = 1'b0;
		// Idle data is not left looking valid
		o_rx_data = ~o_rx_data;
		o_rx_end = 1'b1;
		o_rx_crc_ok = ok;
		@(posedge i_clk_sys);
		#1;
		o_rx_end = 1'b0;
		for (i = 0; i < lim; i++)
		begin
			o_tx_ready = !slow || i[0];
			@(posedge i_clk_sys);
			if (i_tx_valid && o_tx_ready && rn < 8'h0f)
			begin
				rb[rn] = i_tx_data;
				rn++;
				if (i_tx_last)
					i = lim;
			end
			#1;
		end
		o_tx_ready = 1'b0;
	endtask
endmodule // mfr_master

`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("FAIL %0t got %h exp %h", $time, a, b); end end

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// Row: frame, reply, events, register writes
	typedef struct packed {
		logic [7:0] fl;
		logic [87:0] f;
		logic [7:0] rl;
		logic [71:0] r;
		logic [4:0] ev;
		logic [1:0] wn;
	} mfr_row_t;
	mfr_row_t rows [13] = '{
		'{8'd6, 88'h010800001234, 8'd6, 72'h010800001234, 5'h00, 2'd0},
		'{8'd6, 88'h010800011234, 8'd3, 72'h018803, 5'h02, 2'd0},
		'{8'd5, 88'h0108000012, 8'd3, 72'h018803, 5'h01, 2'd0},
		'{8'd11, 88'h01100010000204aabbccdd, 8'd6, 72'h011000100002, 5'h00, 2'd2},
		'{8'd9, 88'h011001000001020001, 8'd3, 72'h019002, 5'h14, 2'd0},
		'{8'd7, 88'h01100010000000, 8'd3, 72'h019003, 5'h18, 2'd0},
		'{8'd9, 88'h011000100065020001, 8'd3, 72'h019003, 5'h18, 2'd0},
		'{8'd9, 88'h011000100001040001, 8'd3, 72'h019003, 5'h11, 2'd0},
		'{8'd9, 88'h01100010000102ffff, 8'd3, 72'h019003, 5'h10, 2'd0},
		'{8'd9, 88'h016406040700050020, 8'd9, 72'h01640604075a055a20, 5'h00, 2'd0},
		'{8'd7, 88'h01640403070005, 8'd3, 72'h01e403, 5'h02, 2'd0},
		'{8'd7, 88'h01640504070005, 8'd3, 72'h01e403, 5'h01, 2'd0},
		'{8'd7, 88'h01640404070100, 8'd3, 72'h01e402, 5'h04, 2'd0}};
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	wire rx_valid, rx_end, crc_ok, tx_ready, tx_valid, tx_last, busy, reg_wr;
	wire [7:0] rx_data, tx_data;
	wire [15:0] reg_addr, reg_wdata;
	wire [4:0] evts;
	logic [4:0] ev = 5'h00; // Events seen this frame
	logic [1:0] wn = 2'd0; // Writes seen this frame
	logic clr = 1'b0; // Restart the per-frame tallies
	logic [15:0] wa = 16'h0000; // Last written address
	logic [15:0] wd = 16'h0000; // Last written data
	int err_count = 0;
	int n_compared = 0;
	int k, j, s;

	// Small map: 0000h-00ffh present, ffffh never legal
	wire wr_ok = reg_addr < 16'h0100;
	wire val_ok = reg_wdata != 16'hffff;
	wire [15:0] rdata = reg_addr ^ 16'h5a00;

	mfr_responder dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
		.i_rx_end(rx_end), .i_rx_crc_ok(crc_ok), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
		.o_tx_data(tx_data), .o_tx_last(tx_last), .o_busy(busy), .o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .i_reg_wr_ok(wr_ok), .i_reg_val_ok(val_ok),
		.i_reg_rd_ok(wr_ok), .i_reg_rdata(rdata), .o_evt_bad_format(evts[0]), .o_evt_illegal_func(evts[1]),
		.o_evt_invalid_addr(evts[2]), .o_evt_illegal_reg(evts[3]), .o_evt_illegal_write(evts[4]));
	mfr_master m (.i_clk_sys(i_clk_sys), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end),
		.o_rx_crc_ok(crc_ok), .o_tx_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.i_tx_last(tx_last));

	// 200 MHz clock
	initial
	begin
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	// Collect events and writes per frame
	always @(posedge i_clk_sys)
	begin
		ev <= (clr ? 5'h00 : ev) | evts;
		wn <= (clr ? 2'd0 : wn) + reg_wr;
		if (reg_wr)
		begin
			wa <= reg_addr;
			wd <= reg_wdata;
		end
	end

	// Tallies have one driver; the bench only asks for a restart
	task automatic clear_acc;
		clr = 1'b1;
		@(posedge i_clk_sys);
		#1;
		clr = 1'b0;
	endtask

	// Verdict and end of run
	task automatic stop_test;
		$display("err_count=%0d n_compared=%0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge i_clk_sys);
		#1;
		i_rst = 1'b0;
		`CHK({busy, tx_valid, reg_wr, evts}, 8'h00)
		// Table pass, then again with a stalling master
		for (s = 0; s < 2; s++)
		begin
			m.slow = s;
			for (k = 0; k < 13; k++)
			begin
				clear_acc();
				m.xfer(rows[k].fl, rows[k].f, 1'b1, 3000);
				`CHK(m.rn, rows[k].rl)
				for (j = 0; j < rows[k].rl; j++)
					`CHK(m.rb[j], rows[k].r[8*(rows[k].rl-1-j)+:8])
				`CHK(ev, rows[k].ev)
				`CHK(wn, rows[k].wn)
			end
		end
		// Only the good write row commits: last word lands at start+1
		`CHK({wa, wd}, 32'h0011ccdd)
		// Bad CRC: no reply, no event
		clear_acc();
		m.xfer(rows[0].fl, rows[0].f, 1'b0, 40);
		`CHK({m.rn, ev}, 13'h0000)
		// Reset in mid-reply, then a clean echo
		fork
			m.xfer(rows[0].fl, rows[0].f, 1'b1, 20);
			begin
				repeat (10) @(posedge i_clk_sys);
				#1;
				i_rst = 1'b1;
				@(posedge i_clk_sys);
				#1;
				`CHK({busy, tx_valid}, 2'b00)
				i_rst = 1'b0;
			end
		join
		m.xfer(rows[0].fl, rows[0].f, 1'b1, 3000);
		`CHK(m.rn, 8'd6)
		stop_test();
	end
endmodule // tb

`default_nettype wire
